// File: mide_pkg.sv
// Constants and types shared by the decode/execute core and its ALU
package mide_pkg;
   // Widths and stack depth
   localparam int IW = 13;
   localparam int PCW = 13;
   localparam int DW = 8;
   localparam int RAW = 6;
   localparam int PCA = 4;
   localparam int STK_DEPTH = 8;
   // Oscillator periods per instruction cycle
   localparam int CLK_PER_ICYC = 2;
   // Special register addresses
   localparam logic [5:0] REG_PC = 6'h02;
   localparam logic [5:0] REG_BANK = 6'h04;
   // Reset values
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic IE_RST = 1'b0;
   localparam logic TO_RST = 1'b1;
   localparam logic PD_RST = 1'b1;
   // Instruction groups
   localparam logic [1:0] GRP_REG = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;
   // Operand-free codes
   localparam logic [3:0] MC_DAA = 4'h1;
   localparam logic [3:0] MC_CTLW = 4'h2;
   localparam logic [3:0] MC_SLEEP = 4'h3;
   localparam logic [3:0] MC_WATCHDOG_CLEAR_INSTR = 4'h4;
   localparam logic [3:0] MC_ENI = 4'h5;
   localparam logic [3:0] MC_IRQ_DISABLE_INSTR = 4'h6;
   localparam logic [3:0] MC_RET = 4'h7;
   localparam logic [3:0] MC_RETURN_FROM_IRQ_INSTR = 4'h8;
   localparam logic [3:0] MC_CTLR = 4'h9;
   // Literal codes
   localparam logic [2:0] LC_MOV = 3'h0;
   localparam logic [2:0] LC_OR = 3'h1;
   localparam logic [2:0] LC_AND = 3'h2;
   localparam logic [2:0] LC_XOR = 3'h3;
   localparam logic [2:0] LC_RETL = 3'h4;
   localparam logic [2:0] LC_SUB = 3'h5;
   localparam logic [2:0] LC_ADD = 3'h6;
   localparam logic [2:0] LC_EXT = 3'h7;
   // Extended literal codes
   localparam logic [1:0] EC_BANK = 2'h0;
   localparam logic [1:0] EC_LCALL = 2'h1;
   localparam logic [1:0] EC_LJMP = 2'h2;
   localparam logic [1:0] EC_TBRD = 2'h3;
   // Bit operation kinds
   localparam logic [1:0] BK_CLR = 2'h0;
   localparam logic [1:0] BK_SET = 2'h1;
   localparam logic [1:0] BK_SKC = 2'h2;
   localparam logic [1:0] BK_SKS = 2'h3;
   // Decimal adjust
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
   localparam logic [7:0] DAA_LO_ADJ = 8'h06;
   localparam logic [7:0] DAA_HI_ADJ = 8'h60;
   typedef enum logic [3:0] {
      AOP_PASSA = 4'h0, AOP_CLR = 4'h1, AOP_SUB = 4'h2, AOP_DEC = 4'h3,
      AOP_OR = 4'h4, AOP_AND = 4'h5, AOP_XOR = 4'h6, AOP_ADD = 4'h7,
      AOP_PASSR = 4'h8, AOP_COM = 4'h9, AOP_INC = 4'ha, AOP_DJZ = 4'hb,
      AOP_RRC = 4'hc, AOP_RLC = 4'hd, AOP_SWAP = 4'he, AOP_JZ = 4'hf
   } mide_aop_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000, ST_SKIP = 3'b001, ST_HOLD = 3'b010,
      ST_LONG = 3'b011, ST_TBL = 3'b100, ST_SLEEP = 3'b101
   } mide_state_t;
   // Instruction word views
   typedef struct packed {
      logic [1:0] grp; logic [3:0] aop; logic dst; logic [5:0] ra;
   } mide_rfrm_t;
   typedef struct packed {
      logic [1:0] grp; logic [1:0] kind; logic [2:0] bsel; logic [5:0] ra;
   } mide_bfrm_t;
   typedef struct packed {
      logic [1:0] grp; logic jmp; logic [9:0] k;
   } mide_jfrm_t;
   typedef struct packed {
      logic [1:0] grp; logic [2:0] code; logic [7:0] k;
   } mide_lfrm_t;
   typedef struct packed {
      logic [7:0] res; logic z; logic c; logic dc; logic wz; logic wc; logic wdc;
   } mide_alu_out_t;
endpackage

// File: mide_alu.sv
// Arithmetic and logic unit with per-operation flag write enables
`timescale 1ns/1ps
module mide_alu (
   // Operation
   input wire mide_pkg::mide_aop_t i_aop,
   input wire logic i_daa,
   // Operands
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_opd,
   input wire logic i_c,
   input wire logic i_dc,
   // Result
   output mide_pkg::mide_alu_out_t o_res
);
   wire [8:0] add_w = {1'b0, i_opd} + {1'b0, i_acc};
   wire [4:0] addn_w = {1'b0, i_opd[3:0]} + {1'b0, i_acc[3:0]};
   wire [8:0] sub_w = {1'b0, i_opd} - {1'b0, i_acc};
   wire [4:0] subn_w = {1'b0, i_opd[3:0]} - {1'b0, i_acc[3:0]};
   wire lo_fix = i_dc || (i_acc[3:0] > mide_pkg::BCD_DIGIT_MAX);
   wire hi_fix = i_c || (i_acc > mide_pkg::BCD_BYTE_MAX);
   wire [7:0] daa_w = i_acc + (lo_fix ? mide_pkg::DAA_LO_ADJ : 8'h00)
                      + (hi_fix ? mide_pkg::DAA_HI_ADJ : 8'h00);
   logic [7:0] res;
   logic c;
   logic dc;
   logic wz;
   logic wc;
   always_comb begin
      res = i_opd;
      c = i_c;
      dc = i_dc;
      wz = 1'b1;
      wc = 1'b0;
      case (i_aop)
         mide_pkg::AOP_PASSA: begin res = i_acc; wz = 1'b0; end
         mide_pkg::AOP_CLR: res = 8'h00;
         mide_pkg::AOP_SUB: begin res = sub_w[7:0]; c = ~sub_w[8]; dc = ~subn_w[4]; wc = 1'b1; end // RULE20
         mide_pkg::AOP_DEC: res = i_opd - 8'h01;
         mide_pkg::AOP_OR: res = i_opd | i_acc;
         mide_pkg::AOP_AND: res = i_opd & i_acc;
         mide_pkg::AOP_XOR: res = i_opd ^ i_acc;
         mide_pkg::AOP_ADD: begin res = add_w[7:0]; c = add_w[8]; dc = addn_w[4]; wc = 1'b1; end // RULE20
         mide_pkg::AOP_COM: res = ~i_opd;
         mide_pkg::AOP_INC: res = i_opd + 8'h01;
         mide_pkg::AOP_DJZ: begin res = i_opd - 8'h01; wz = 1'b0; end // RULE11
         mide_pkg::AOP_JZ: begin res = i_opd + 8'h01; wz = 1'b0; end // RULE12
         mide_pkg::AOP_RRC: begin res = {i_c, i_opd[7:1]}; c = i_opd[0]; wz = 1'b0; wc = 1'b1; end // RULE13
         mide_pkg::AOP_RLC: begin res = {i_opd[6:0], i_c}; c = i_opd[7]; wz = 1'b0; wc = 1'b1; end // RULE14
         mide_pkg::AOP_SWAP: begin res = {i_opd[3:0], i_opd[7:4]}; wz = 1'b0; end
         default: res = i_opd;
      endcase
      if (i_daa) begin
         res = daa_w;
         c = hi_fix | i_c;
         wz = 1'b0;
         wc = 1'b1; // RULE21
      end
   end
   assign o_res = '{res: res, z: (res == 8'h00), c: c, dc: dc, wz: wz, wc: wc,
                    wdc: (wc && !i_daa && (i_aop == mide_pkg::AOP_ADD
                                           || i_aop == mide_pkg::AOP_SUB))};
endmodule // mide_alu

// File: mide_core.sv
// Instruction decode and execute control for the 8-bit core
`timescale 1ns/1ps
// Functional notes
// (RULE1) Instruction words are 13 bits: operation field plus operand fields.
// (RULE2) One instruction cycle is two clocks; ordinary instructions take one.
// (RULE3) Any write to the program counter register costs two instruction cycles.
// (RULE4) A taken conditional skip costs two cycles and discards the skipped word.
// (RULE5) Jump, call and all returns take one instruction cycle.
// (RULE6) Any bit of any register can be set, cleared or tested.
// (RULE7) Port registers are addressed and operated on like general registers.
// (RULE8) Literals are 8 bits for data and 10 bits for jump targets.
// (RULE9) Return from interrupt pops the stack and re-enables interrupts.
// (RULE10) Sleep clears watchdog, stops oscillator, updates flags; clear updates both.
// (RULE11) Decrement-skip writes value minus one, skips on zero, flags untouched.
// (RULE12) Increment-skip writes value plus one, skips on zero, flags untouched.
// (RULE13) Rotate right through carry: bit 0 to carry, carry to bit 7.
// (RULE14) Rotate left through carry: bit 7 to carry, carry to bit 0.
// (RULE15) Short call pushes next address; short call and jump use page plus literal.
// (RULE16) Return with literal loads the accumulator and pops the stack.
// (RULE17) Long call takes target from next word and pushes return address.
// (RULE18) Long jump takes target from next word without a push.
// (RULE19) Table read copies low byte, or high five bits with upper bits cleared.
// (RULE20) Add and subtract update zero, carry, digit carry; subtract is operand minus A.
// (RULE21) Logic and move ops set zero only; adjust and rotates set carry only. Literal move and move from A (AOP_PASSA) set no flags here.
// (RULE22) Bank select loads bits 7:6 of bank register, no flags touched.
module mide_core #(
   parameter int STACK_DEPTH = mide_pkg::STK_DEPTH
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Program memory, data valid in the cycle its address is shown
   output logic [mide_pkg::PCW-1:0] o_pm_addr,
   input wire logic [mide_pkg::IW-1:0] i_pm_data,
   // Register file including port data registers
   output logic [mide_pkg::RAW-1:0] o_rf_addr,
   input wire logic [mide_pkg::DW-1:0] i_rf_rdata,
   output logic o_rf_we,
   output logic [mide_pkg::DW-1:0] o_rf_wdata,
   input wire logic i_tbl_half,
   // Core control register
   output logic o_ctrl_we,
   output logic [mide_pkg::DW-1:0] o_ctrl_wdata,
   input wire logic [mide_pkg::DW-1:0] i_ctrl_rdata,
   // Port control registers
   output logic o_pctl_we,
   output logic [mide_pkg::PCA-1:0] o_pctl_addr,
   output logic [mide_pkg::DW-1:0] o_pctl_wdata,
   input wire logic [mide_pkg::DW-1:0] i_pctl_rdata,
   // Power and watchdog
   input wire logic i_wake,
   output logic o_wdt_clr,
   output logic o_osc_stop,
   output logic o_timeout_flag,
   output logic o_power_flag,
   // Core state
   output logic o_irq_en,
   output logic [mide_pkg::DW-1:0] o_acc,
   output logic o_zero,
   output logic o_carry,
   output logic o_digit_carry
);
   localparam int SPW = $clog2(STACK_DEPTH);

   mide_pkg::mide_state_t state_reg;
   mide_pkg::mide_state_t state_next;
   logic ph_reg;
   logic [mide_pkg::IW-1:0] ir_reg;
   logic [mide_pkg::IW-1:0] lw_reg;
   logic [mide_pkg::PCW-1:0] pc_reg;
   logic [mide_pkg::PCW-1:0] pc_next;
   logic [mide_pkg::PCW-1:0] pm_addr_reg;
   logic [mide_pkg::DW-1:0] acc_reg;
   logic z_reg;
   logic c_reg;
   logic dc_reg;
   logic ie_reg;
   logic to_reg;
   logic pd_reg;
   logic wdt_clr_reg;
   logic osc_stop_reg;
   logic [mide_pkg::RAW-1:0] rf_addr_reg;
   logic rf_we_reg;
   logic [mide_pkg::DW-1:0] rf_wdata_reg;
   logic ctrl_we_reg;
   logic pctl_we_reg;
   logic [mide_pkg::PCA-1:0] pctl_addr_reg;
   logic [mide_pkg::PCW-1:0] stk_mem [STACK_DEPTH];
   logic [SPW-1:0] sp_reg;
   logic wk1_reg;
   logic wk2_reg;
   logic wk3_reg;

   // Instruction word views
   mide_pkg::mide_rfrm_t rw;
   mide_pkg::mide_bfrm_t bw;
   mide_pkg::mide_jfrm_t jw;
   mide_pkg::mide_lfrm_t lw;
   mide_pkg::mide_lfrm_t fw;
   assign rw = ir_reg; // RULE1
   assign bw = ir_reg;
   assign jw = ir_reg;
   assign lw = ir_reg;
   assign fw = i_pm_data;

   // Group decode
   wire misc = (rw.grp == mide_pkg::GRP_REG) && (rw.aop == 4'h0) && !rw.dst;
   wire is_io = misc && rw.ra[5];
   wire [3:0] mcode = rw.ra[3:0];
   wire is_mc = misc && !rw.ra[5];
   wire regop = (rw.grp == mide_pkg::GRP_REG) && !misc;
   wire bitop = bw.grp == mide_pkg::GRP_BIT;
   wire is_call = (jw.grp == mide_pkg::GRP_JMP) && !jw.jmp;
   wire is_jmp = (jw.grp == mide_pkg::GRP_JMP) && jw.jmp;
   wire litop = lw.grp == mide_pkg::GRP_LIT;
   wire is_ext = litop && (lw.code == mide_pkg::LC_EXT);
   wire [1:0] ecode = lw.k[7:6];
   wire is_bank = is_ext && (ecode == mide_pkg::EC_BANK);
   wire is_lcall = is_ext && (ecode == mide_pkg::EC_LCALL);
   wire is_ljmp = is_ext && (ecode == mide_pkg::EC_LJMP);
   wire is_tbrd = is_ext && (ecode == mide_pkg::EC_TBRD);
   wire is_retl = litop && (lw.code == mide_pkg::LC_RETL);
   wire is_ret = is_mc && (mcode == mide_pkg::MC_RET);
   wire is_return_from_irq_instr = is_mc && (mcode == mide_pkg::MC_RETURN_FROM_IRQ_INSTR);
   wire is_sleep = is_mc && (mcode == mide_pkg::MC_SLEEP);
   wire is_watchdog_clear_instr = is_mc && (mcode == mide_pkg::MC_WATCHDOG_CLEAR_INSTR);
   wire is_daa = is_mc && (mcode == mide_pkg::MC_DAA);
   wire is_ctlr = is_mc && (mcode == mide_pkg::MC_CTLR);
   wire is_pop = is_ret || is_return_from_irq_instr || is_retl;
   wire f_bank = (fw.grp == mide_pkg::GRP_LIT) && (fw.code == mide_pkg::LC_EXT)
                 && (fw.k[7:6] == mide_pkg::EC_BANK);

   // Operand fetch; the program counter register reads the live counter
   wire [7:0] r_val = (rf_addr_reg == mide_pkg::REG_PC) ? pc_reg[7:0] : i_rf_rdata; // RULE7
   wire [2:0] lcode = lw.code;
   wire [3:0] lit_aop = (lcode == mide_pkg::LC_OR) ? mide_pkg::AOP_OR :
                        (lcode == mide_pkg::LC_AND) ? mide_pkg::AOP_AND :
                        (lcode == mide_pkg::LC_XOR) ? mide_pkg::AOP_XOR :
                        (lcode == mide_pkg::LC_SUB) ? mide_pkg::AOP_SUB :
                        (lcode == mide_pkg::LC_ADD) ? mide_pkg::AOP_ADD : mide_pkg::AOP_PASSR;
   wire [3:0] aop_sel = litop ? lit_aop : (is_daa ? mide_pkg::AOP_PASSA : rw.aop);
   wire [7:0] opd = litop ? lw.k : r_val; // RULE8
   mide_pkg::mide_alu_out_t alu;

   mide_alu u_alu (
      .i_aop(mide_pkg::mide_aop_t'(aop_sel)),
      .i_daa(is_daa),
      .i_acc(acc_reg),
      .i_opd(opd),
      .i_c(c_reg),
      .i_dc(dc_reg),
      .o_res(alu)
   );

   // Bit operations on any register
   wire [7:0] bmask = 8'h01 << bw.bsel;
   wire bit_val = r_val[bw.bsel];
   wire [7:0] bit_res = (bw.kind == mide_pkg::BK_SET) ? (r_val | bmask) : (r_val & ~bmask); // RULE6
   wire bit_wr = bitop && ((bw.kind == mide_pkg::BK_SET) || (bw.kind == mide_pkg::BK_CLR));

   // Write-back selection
   wire lit_noflag = litop && ((lcode == mide_pkg::LC_MOV) || is_retl || is_ext);
   wire wr_acc = (regop && !rw.dst) || (litop && !is_ext) || is_daa || is_ctlr
                 || (is_io && !rw.ra[4]);
   wire wr_reg = (regop && rw.dst) || bit_wr || is_bank;
   wire [7:0] reg_wd = is_bank ? {lw.k[1:0], r_val[5:0]} : (bitop ? bit_res : alu.res); // RULE22
   wire [7:0] acc_wd = is_ctlr ? i_ctrl_rdata : (is_io ? i_pctl_rdata : alu.res); // RULE16
   wire fl_en = (regop || litop || is_daa) && !lit_noflag;
   wire skip_aop = (rw.aop == mide_pkg::AOP_DJZ) || (rw.aop == mide_pkg::AOP_JZ);
   wire skip = (regop && skip_aop && alu.z) // RULE11 RULE12
               || (bitop && (bw.kind == mide_pkg::BK_SKC) && !bit_val)
               || (bitop && (bw.kind == mide_pkg::BK_SKS) && bit_val);
   wire pc_wr = wr_reg && (rf_addr_reg == mide_pkg::REG_PC); // RULE3

   // Stack
   wire [SPW-1:0] sp_inc = SPW'(sp_reg + 1'b1);
   wire [SPW-1:0] sp_dec = SPW'(sp_reg - 1'b1);
   wire [mide_pkg::PCW-1:0] pc_inc = pc_reg + 1'b1;
   wire [mide_pkg::PCW-1:0] tos = stk_mem[sp_dec];
   wire [mide_pkg::PCW-1:0] short_tgt = {pc_reg[12:10], jw.k}; // RULE15
   wire [mide_pkg::PCW-1:0] tbl_addr = {pc_reg[12:8], acc_reg};
   wire ex = ph_reg && (state_reg == mide_pkg::ST_RUN);
   wire lg = ph_reg && (state_reg == mide_pkg::ST_LONG);
   wire push = (ex && is_call) || (lg && is_lcall); // RULE17
   wire pop = ex && is_pop;
   wire [mide_pkg::PCW-1:0] push_val = pc_inc;
   wire woke = wk2_reg && wk3_reg;

   assign pc_next = is_pop ? tos : // RULE5 RULE9 RULE16
                    (is_call || is_jmp) ? short_tgt :
                    pc_wr ? {pc_reg[12:8], reg_wd} : pc_inc;
   assign state_next = skip ? mide_pkg::ST_SKIP : // RULE4
                       pc_wr ? mide_pkg::ST_HOLD :
                       (is_lcall || is_ljmp) ? mide_pkg::ST_LONG :
                       is_tbrd ? mide_pkg::ST_TBL :
                       is_sleep ? mide_pkg::ST_SLEEP : mide_pkg::ST_RUN;

   // Two-clock instruction cycle: fetch phase then execute phase
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ph_reg <= 1'b0;
      end else begin
         ph_reg <= ~ph_reg; // RULE2
      end
   end

   // Wake pin synchroniser
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {wk1_reg, wk2_reg, wk3_reg} <= 3'h0;
      end else begin
         {wk1_reg, wk2_reg, wk3_reg} <= {i_wake, wk1_reg, wk2_reg};
      end
   end

   // Stack storage needs no reset
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         stk_mem[sp_reg] <= (lg ? pc_inc : push_val);
      end
   end

   // Sequencing, counter and fetch
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= mide_pkg::ST_RUN;
         ir_reg <= '0;
         lw_reg <= '0;
         pc_reg <= mide_pkg::PC_RST;
         pm_addr_reg <= mide_pkg::PC_RST;
         sp_reg <= '0;
         rf_addr_reg <= '0;
         pctl_addr_reg <= '0;
      end else begin
         if (!ph_reg && (state_reg == mide_pkg::ST_RUN)) begin
            ir_reg <= i_pm_data;
            rf_addr_reg <= f_bank ? mide_pkg::REG_BANK : fw.k[5:0];
            pctl_addr_reg <= fw.k[3:0];
         end
         if (!ph_reg && (state_reg == mide_pkg::ST_LONG)) begin
            lw_reg <= i_pm_data; // RULE17 RULE18
         end
         if (push) begin
            sp_reg <= sp_inc;
         end else if (pop) begin
            sp_reg <= sp_dec;
         end
         if (ex) begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            pm_addr_reg <= is_tbrd ? tbl_addr : pc_next;
         end else if (ph_reg) begin
            case (state_reg)
               mide_pkg::ST_SKIP: begin
                  pc_reg <= pc_inc; // RULE4
                  pm_addr_reg <= pc_inc;
                  state_reg <= mide_pkg::ST_RUN;
               end
               mide_pkg::ST_LONG: begin
                  pc_reg <= lw_reg;
                  pm_addr_reg <= lw_reg;
                  state_reg <= mide_pkg::ST_RUN;
               end
               mide_pkg::ST_SLEEP: begin
                  if (woke) begin
                     state_reg <= mide_pkg::ST_RUN;
                  end
               end
               default: begin
                  pm_addr_reg <= pc_reg;
                  state_reg <= mide_pkg::ST_RUN;
               end
            endcase
         end
      end
   end

   // Data path state and one-clock strobes
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         acc_reg <= mide_pkg::ACC_RST;
         {z_reg, c_reg, dc_reg} <= 3'h0;
         ie_reg <= mide_pkg::IE_RST;
         to_reg <= mide_pkg::TO_RST;
         pd_reg <= mide_pkg::PD_RST;
         {wdt_clr_reg, rf_we_reg, ctrl_we_reg, pctl_we_reg} <= 4'h0;
         rf_wdata_reg <= '0;
         osc_stop_reg <= 1'b0;
      end else begin
         wdt_clr_reg <= ex && (is_sleep || is_watchdog_clear_instr); // RULE10
         rf_we_reg <= ex && wr_reg;
         ctrl_we_reg <= ex && is_mc && (mcode == mide_pkg::MC_CTLW);
         pctl_we_reg <= ex && is_io && rw.ra[4];
         if (ex && wr_reg) begin
            rf_wdata_reg <= reg_wd;
         end
         if (!ph_reg && (state_reg == mide_pkg::ST_TBL)) begin
            rf_we_reg <= 1'b1;
            rf_wdata_reg <= i_tbl_half ? {3'h0, i_pm_data[12:8]} : i_pm_data[7:0]; // RULE19
         end
         if (ex && wr_acc) begin
            acc_reg <= acc_wd;
         end
         if (ex && fl_en) begin
            if (alu.wz) z_reg <= alu.z; // RULE21
            if (alu.wc) c_reg <= alu.c;
            if (alu.wdc) dc_reg <= alu.dc; // RULE20
         end
         if (ex && (is_return_from_irq_instr || (is_mc && mcode == mide_pkg::MC_ENI))) begin
            ie_reg <= 1'b1; // RULE9
         end else if (ex && is_mc && (mcode == mide_pkg::MC_IRQ_DISABLE_INSTR)) begin
            ie_reg <= 1'b0;
         end
         if (ex && (is_sleep || is_watchdog_clear_instr)) begin
            to_reg <= 1'b1;
            pd_reg <= is_watchdog_clear_instr;
         end
         if (ex && is_sleep) begin
            osc_stop_reg <= 1'b1;
         end else if (ph_reg && (state_reg == mide_pkg::ST_SLEEP) && woke) begin
            osc_stop_reg <= 1'b0;
         end
      end
   end

   assign o_pm_addr = pm_addr_reg;
   assign o_rf_addr = rf_addr_reg;
   assign o_rf_we = rf_we_reg;
   assign o_rf_wdata = rf_wdata_reg;
   assign o_ctrl_we = ctrl_we_reg;
   assign o_ctrl_wdata = acc_reg;
   assign o_pctl_we = pctl_we_reg;
   assign o_pctl_addr = pctl_addr_reg;
   assign o_pctl_wdata = acc_reg;
   assign o_wdt_clr = wdt_clr_reg;
   assign o_osc_stop = osc_stop_reg;
   assign o_timeout_flag = to_reg;
   assign o_power_flag = pd_reg;
   assign o_irq_en = ie_reg;
   assign o_acc = acc_reg;
   assign o_zero = z_reg;
   assign o_carry = c_reg;
   assign o_digit_carry = dc_reg;

   // Checks
   a_phase_toggle: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE2
      ph_reg |=> !ph_reg ##1 ph_reg) else $error("phase did not alternate");
   a_pcwr_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE3
      ex && pc_wr |=> state_reg == mide_pkg::ST_HOLD ##2 state_reg == mide_pkg::ST_RUN)
      else $error("pc write not two cycles");
   a_skip_flush: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE4
      ex && skip |-> ##3 pc_reg == mide_pkg::PCW'($past(pc_reg, 3) + 2'd2))
      else $error("skip did not discard one word");
   a_ret_one: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE5
      ex && is_ret |=> state_reg == mide_pkg::ST_RUN && pc_reg == $past(tos))
      else $error("return not single cycle");
   a_return_from_irq_instr_irq: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE9
      ex && is_return_from_irq_instr |=> o_irq_en && sp_reg == $past(sp_dec))
      else $error("return_from_irq_instr did not enable interrupts");
   a_sleep_flags: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE10
      ex && is_sleep |=> o_wdt_clr && o_osc_stop && o_timeout_flag && !o_power_flag
      ##1 !o_wdt_clr) else $error("sleep effects wrong");
   a_rrc_carry: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE13
      ex && regop && rw.dst && rw.aop == mide_pkg::AOP_RRC
      |=> o_rf_wdata[7] == $past(c_reg) && o_carry == $past(r_val[0]))
      else $error("rotate right carry wrong");
   a_call_push: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE15
      ex && is_call |=> sp_reg == $past(sp_inc) && pc_reg == $past(short_tgt))
      else $error("short call wrong");
   a_ljmp_tgt: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE18
      lg && is_ljmp |=> pc_reg == $past(lw_reg) && sp_reg == $past(sp_reg))
      else $error("long jump wrong");
   a_tbl_high: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE19
      !ph_reg && state_reg == mide_pkg::ST_TBL && i_tbl_half
      |=> o_rf_we && o_rf_wdata[7:5] == 3'h0) else $error("table high half wrong");
endmodule // mide_core

// File: mide_mem_model.sv
// Program memory, register file and control registers facing the core
`timescale 1ns/1ps
module mide_mem_model (
   // Clock
   input wire logic i_core_clk,
   // Program memory
   input wire logic [12:0] i_pm_addr,
   output logic [12:0] o_pm_data,
   // Register file
   input wire logic [5:0] i_rf_addr,
   output logic [7:0] o_rf_rdata,
   input wire logic i_rf_we,
   input wire logic [7:0] i_rf_wdata,
   // Control registers
   input wire logic i_ctrl_we,
   input wire logic [7:0] i_ctrl_wdata,
   output logic [7:0] o_ctrl_rdata,
   input wire logic i_pctl_we,
   input wire logic [3:0] i_pctl_addr,
   input wire logic [7:0] i_pctl_wdata,
   output logic [7:0] o_pctl_rdata
);
   logic [12:0] pm [8192];
   logic [7:0] rf [64];
   logic [7:0] pctl [16];
   logic [7:0] ctrl_reg = 8'h00;
   // Empty memory reads as no-op so a stray fetch stays harmless
   initial begin
      foreach (pm[i]) pm[i] = 13'h0000;
      foreach (rf[i]) rf[i] = 8'h00;
      foreach (pctl[i]) pctl[i] = 8'h00;
   end
   assign o_pm_data = pm[i_pm_addr];
   assign o_rf_rdata = rf[i_rf_addr];
   assign o_ctrl_rdata = ctrl_reg;
   assign o_pctl_rdata = pctl[i_pctl_addr];
   always @(posedge i_core_clk) begin
      if (i_rf_we) rf[i_rf_addr] <= i_rf_wdata;
      if (i_ctrl_we) ctrl_reg <= i_ctrl_wdata;
      if (i_pctl_we) pctl[i_pctl_addr] <= i_pctl_wdata;
   end
endmodule // mide_mem_model

// File: mide_core_tb_top.sv
// Self-checking bench for the decode/execute core
`timescale 1ns/1ps
module mide_core_tb_top;
   logic i_core_clk, i_arst_n, i_tbl_half, i_wake, o_rf_we, o_ctrl_we, o_pctl_we, o_osc_stop;
   logic o_timeout_flag, o_power_flag, o_irq_en, o_zero, o_carry, o_digit_carry, o_wdt_clr;
   logic [12:0] o_pm_addr, i_pm_data;
   logic [5:0] o_rf_addr;
   logic [7:0] i_rf_rdata, o_rf_wdata, o_ctrl_wdata, i_ctrl_rdata, o_pctl_wdata, i_pctl_rdata;
   logic [7:0] o_acc;
   logic [3:0] o_pctl_addr;
   int n_errors = 0;
   int checks = 0;
   int n_wdt = 0;
   // Run after wake: control, port, bit, table high half, long call, returns
   logic [12:0] tail [17] = '{13'h0002, 13'h185a, 13'h0033, 13'h0009, 13'h0047, 13'h0647,
      13'h09c7, 13'h0023, 13'h0005, 13'h1fc8, 13'h1f40, 13'h00cb, 13'h10cd, 13'h14ca,
      13'h0006, 13'h0008, 13'h0007};
   // Row: address, word, instruction cycles, acc, next pc, {z,c,dc}
   logic [51:0] rows [18] = '{
      {13'h0000, 13'h183c, 2'h1, 8'h3c, 13'h0001, 3'h0}, {13'h0001, 13'h0045, 2'h1, 8'h3c, 13'h0002, 3'h0},
      {13'h0002, 13'h1ec4, 2'h1, 8'h00, 13'h0003, 3'h7}, {13'h0003, 13'h0785, 2'h1, 8'h3d, 13'h0004, 3'h7},
      {13'h0004, 13'h0e85, 2'h2, 8'h3d, 13'h0006, 3'h7}, {13'h0006, 13'h0605, 2'h1, 8'h9e, 13'h0007, 3'h5},
      {13'h0007, 13'h0685, 2'h1, 8'h78, 13'h0008, 3'h5}, {13'h0008, 13'h1d78, 2'h1, 8'h00, 13'h0009, 3'h7},
      {13'h0009, 13'h0585, 2'h1, 8'h3b, 13'h000a, 3'h7}, {13'h000a, 13'h1020, 2'h1, 8'h3b, 13'h0020, 3'h7},
      {13'h0020, 13'h1c55, 2'h1, 8'h55, 13'h000b, 3'h7}, {13'h000b, 13'h1f80, 2'h2, 8'h55, 13'h0030, 3'h7},
      {13'h0030, 13'h1fc6, 2'h2, 8'h55, 13'h0031, 3'h7}, {13'h0031, 13'h0406, 2'h1, 8'hbc, 13'h0032, 3'h3},
      {13'h0032, 13'h0004, 2'h1, 8'hbc, 13'h0033, 3'h3}, {13'h0033, 13'h1f02, 2'h1, 8'hbc, 13'h0034, 3'h3},
      {13'h0034, 13'h0042, 2'h2, 8'hbc, 13'h00bc, 3'h3}, {13'h00bc, 13'h0003, 2'h1, 8'hbc, 13'h00bd, 3'h3}};
   mide_core dut (.i_core_clk, .i_arst_n, .o_pm_addr, .i_pm_data, .o_rf_addr, .i_rf_rdata,
      .o_rf_we, .o_rf_wdata, .i_tbl_half, .o_ctrl_we, .o_ctrl_wdata, .i_ctrl_rdata, .o_pctl_we,
      .o_pctl_addr, .o_pctl_wdata, .i_pctl_rdata, .i_wake, .o_wdt_clr, .o_osc_stop,
      .o_timeout_flag, .o_power_flag, .o_irq_en, .o_acc, .o_zero, .o_carry, .o_digit_carry);
   mide_mem_model u_mem (.i_core_clk, .i_pm_addr(o_pm_addr), .o_pm_data(i_pm_data),
      .i_rf_addr(o_rf_addr), .o_rf_rdata(i_rf_rdata), .i_rf_we(o_rf_we), .i_rf_wdata(o_rf_wdata),
      .i_ctrl_we(o_ctrl_we), .i_ctrl_wdata(o_ctrl_wdata), .o_ctrl_rdata(i_ctrl_rdata),
      .i_pctl_we(o_pctl_we), .i_pctl_addr(o_pctl_addr), .i_pctl_wdata(o_pctl_wdata),
      .o_pctl_rdata(i_pctl_rdata));
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   // Strobe counted mid-cycle, where it is settled
   always @(negedge i_core_clk) begin
      if (o_wdt_clr === 1'b1) n_wdt++;
   end
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      i_arst_n = 1'b0;
      i_tbl_half = 1'b0;
      i_wake = 1'b0;
      #1;
      foreach (rows[i]) u_mem.pm[rows[i][51:39]] = rows[i][38:26];
      // Word after the taken skip would clobber acc if executed
      u_mem.pm[13'h0005] = 13'h18ff;
      u_mem.pm[13'h000c] = 13'h0030;
      u_mem.pm[13'h0055] = 13'h1abc;
      u_mem.pm[13'h005a] = 13'h1abc;
      foreach (tail[i]) u_mem.pm[13'h00bd + i] = tail[i];
      repeat (2) @(posedge i_core_clk);
      #1 i_arst_n = 1'b1;
      foreach (rows[i]) begin
         repeat (2 * rows[i][25:24]) @(posedge i_core_clk);
         #1;
         chk(o_acc, rows[i][23:16]);
         chk(o_pm_addr, rows[i][15:3]);
         chk({o_zero, o_carry, o_digit_carry}, rows[i][2:0]);
      end
      chk(u_mem.rf[5], 8'h3c);
      chk(u_mem.rf[6], 8'hbc);
      chk(u_mem.rf[4], 8'h80);
      chk({o_osc_stop, o_timeout_flag, o_power_flag}, 3'b110);
      $display("program run done");
      i_wake = 1'b1;
      i_tbl_half = 1'b1;
      for (int k = 0; k < 20 && o_osc_stop !== 1'b0; k++) @(posedge i_core_clk);
      #1 chk(o_osc_stop, 1'b0);
      $display("wake done");
      repeat (60) @(posedge i_core_clk);
      #1;
      chk(u_mem.ctrl_reg, 8'hbc);
      chk(u_mem.pctl[3], 8'h5a);
      chk(u_mem.rf[7], 8'h5e);
      chk(u_mem.rf[8], 8'h1a);
      chk({o_acc, o_irq_en}, 9'h0b5);
      chk({o_zero, o_carry, o_digit_carry}, 3'h1);
      chk(o_pm_addr, 13'h00ca);
      chk(n_wdt, 13'h0002);
      $display("tail program done");
      i_arst_n = 1'b0;
      #1;
      chk({o_acc, o_irq_en, o_timeout_flag, o_power_flag}, 11'h003);
      chk(o_pm_addr, 13'h0000);
      $display("reset done");
      wrap_up();
   end
endmodule // mide_core_tb_top
